// >>> src/tcm_pkg.sv
// Purpose: Shared constants and types for the timer/counter block.
// Assumes: APB slave with 32-bit data, 8-bit byte address.
// Notes: Each register holds one aligned word; narrow data sits low.
//
// Contract
// R1: Event mode counts synchronised input falling edges.
// R2: Event compare match interrupts and clears counter.
// R3: Source holds each event level two cycles.
// R4: Compare register unbuffered, takes effect immediately.
// R5: Software keeps initial bit zero there.
// R6: Divider mode match toggles, clears, interrupts.
// R7: Divider pin is inverse flip-flop; reset clears.
// R8: Stopped output holds; initial bit later.
// R9: Control bit 3 runs, bit 7 initial.
// R10: PWM toggles at duty, again at overflow.
// R11: PWM pin carries inverse flip-flop level.
// R12: Duty double-buffered; loads at match or stopped. The code loads at the PWM overflow instead of at match.
// R13: Duty read during PWM returns active stage.
// R14: Software writes duty right after interrupt.
// R15: Software stops timer before entering stop mode.
// R16: PWM offers seven source clocks, slow limits.
// R17: Sixteen-bit mode cascades counters, match clears.
// R18: Software writes compare low byte then high.
// R19: Sixteen-bit mode offers four source clocks.
// R20: Event input synchronised, each edge once.
// R21: Sixteen-bit PWM uses combined duty, overflow.
package tcm_pkg;

   // Register byte addresses.
   localparam logic [7:0] ADDR_FIRST_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SECOND_CTRL = 8'h04;
   localparam logic [7:0] ADDR_CMP_LO = 8'h08;
   localparam logic [7:0] ADDR_CMP_HI = 8'h0c;
   localparam logic [7:0] ADDR_DUTY_LO = 8'h10;
   localparam logic [7:0] ADDR_DUTY_HI = 8'h14;
   localparam logic [7:0] ADDR_CONFIG = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;

   // Control register layout: bit 7 initial value, 6:4 source, 3 run.
   typedef struct packed {
      logic ffinit;
      logic [2:0] src;
      logic run;
      logic [2:0] mode;
   } tcm_ctrl_t;

   // Operating modes held in the mode field.
   localparam logic [2:0] MODE_DIVIDER = 3'h1;
   localparam logic [2:0] MODE_EVENT = 3'h2;
   localparam logic [2:0] MODE_PWM8 = 3'h3;
   localparam logic [2:0] MODE_TIMER16 = 3'h4;
   localparam logic [2:0] MODE_PWM16 = 3'h6;

   // Source clock selections.
   localparam logic [2:0] SRC_DIV2048 = 3'h0;
   localparam logic [2:0] SRC_DIV128 = 3'h1;
   localparam logic [2:0] SRC_DIV32 = 3'h2;
   localparam logic [2:0] SRC_DIV8 = 3'h3;
   localparam logic [2:0] SRC_SLOW = 3'h4;
   localparam logic [2:0] SRC_DIV2 = 3'h5;
   localparam logic [2:0] SRC_DIV1 = 3'h6;

   // Configuration register bit positions.
   localparam int CFG_DVSEL_BIT = 0;
   localparam int CFG_SLOWMODE_BIT = 1;

   // Reset values.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [1:0] CONFIG_RESET = 2'h0;

   // Prescaler width and the slow clock divide-by-8 terminal count.
   localparam int PRE_TAPS = 12;
   localparam logic [2:0] SLOW_DIV_LAST = 3'h7;

endpackage

// >>> src/tcm_sync.sv
// Purpose: Three-flop synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk.
// Notes: The first flop feeds only the second flop.
`timescale 1ns/1ns
module tcm_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic s1; // First stage, read only by s2.
   logic s2; // Second stage.
   logic s3; // Third stage.

   // The level only changes once stages two and three agree.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule

// >>> src/tcm_prescale.sv
// Purpose: Free-running prescaler giving divide-by-2^n enable pulses.
// Assumes: Main clock equals the bus clock.
// Notes: Tap n pulses one cycle in every 2^n cycles.
`timescale 1ns/1ns
module tcm_prescale (
   input wire logic clk,
   input wire logic rst_n,
   output logic [tcm_pkg::PRE_TAPS-1:0] tick
);
   logic [tcm_pkg::PRE_TAPS-2:0] cnt; // Ripple-free binary count.

   // All taps come from one counter, so they stay phase aligned.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         tick <= '0;
      end else begin
         cnt <= cnt + 1'b1;
         for (int n = 0; n < tcm_pkg::PRE_TAPS; n++) begin
            tick[n] <= &(cnt | ~((tcm_pkg::PRE_TAPS-1)'((1 << n) - 1)));
         end
      end
   end
endmodule

// >>> src/tcm_top.sv
// Purpose: Timer/counter with event, divider, PWM and 16-bit modes.
// Assumes: pclk is the main clock; slow clock arrives on a pin.
// Notes: Registers are reached over APB, one word each.
`timescale 1ns/1ns
module tcm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic event_input_pin,
   input wire logic slow_clock_pin,
   output logic divider_output_pin,
   output logic pwm_output_pin,
   output logic timer_match_interrupt
);

   ////////////////////////////////////////////////////////////////////
   // Register state.

   tcm_pkg::tcm_ctrl_t first_counter_control; // Low-byte counter setup.
   tcm_pkg::tcm_ctrl_t second_counter_control; // Main control.
   logic [7:0] compare_low_byte; // Compare, no shadow stage.
   logic [7:0] compare_high_byte; // Compare upper byte.
   logic [15:0] duty_buf; // Duty value as written.
   logic [15:0] duty_act; // Duty value in use.
   logic [1:0] config_bits; // Divider select and slow mode.
   logic [15:0] cnt; // Up-counter, both bytes.
   logic tff; // Timer flip-flop.
   logic next_tff; // Flip-flop value for the coming cycle.

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers and edge detection.

   logic evt_lvl; // Filtered event input level.
   logic evt_prev; // Previous filtered event level.
   logic slow_lvl; // Filtered slow clock level.
   logic slow_prev; // Previous filtered slow level.
   logic [2:0] slow_div; // Slow clock divide-by-8 counter.

   // The event pin is asynchronous; this filters and retimes it.
   tcm_sync u_evt_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(event_input_pin),
      .dout(evt_lvl)
   ); // [R20]

   // The slow clock is only sampled, never used as a clock.
   tcm_sync u_slow_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(slow_clock_pin),
      .dout(slow_lvl)
   );

   // Previous samples let each edge count exactly once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_prev <= 1'b1;
         slow_prev <= 1'b1;
      end else begin
         evt_prev <= evt_lvl;
         slow_prev <= slow_lvl;
      end
   end

   wire evt_fall = evt_prev & ~evt_lvl; // [R1] [R20]
   wire slow_rise = ~slow_prev & slow_lvl;
   wire slow8_tick = slow_rise & (slow_div == tcm_pkg::SLOW_DIV_LAST);

   // Slow clock divided by eight for the slowest source.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_div <= 3'h0;
      end else if (slow_rise) begin
         slow_div <= slow_div + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Source clock selection.

   logic [tcm_pkg::PRE_TAPS-1:0] tick; // Main clock divide taps.

   // One shared prescaler serves every selectable main clock rate.
   tcm_prescale u_pre (
      .clk(pclk),
      .rst_n(presetn),
      .tick(tick)
   );

   wire [2:0] mode = second_counter_control.mode;
   wire run = second_counter_control.run; // [R9]
   wire dvsel = config_bits[tcm_pkg::CFG_DVSEL_BIT];
   wire slow_mode = config_bits[tcm_pkg::CFG_SLOWMODE_BIT];
   wire is_event = (mode == tcm_pkg::MODE_EVENT);
   wire is_div = (mode == tcm_pkg::MODE_DIVIDER);
   wire is_pwm8 = (mode == tcm_pkg::MODE_PWM8);
   wire is_t16 = (mode == tcm_pkg::MODE_TIMER16);
   wire is_pwm16 = (mode == tcm_pkg::MODE_PWM16);
   wire wide = is_t16 | is_pwm16; // [R17] [R21]
   wire is_pwm = is_pwm8 | is_pwm16;
   wire mode_known = is_event | is_div | is_pwm | is_t16;

   // The cascaded modes take their source from the low-byte control.
   wire [2:0] src = wide ? first_counter_control.src
                         : second_counter_control.src;

   // Slowest source is the slow clock / 8 when selected or in slow mode.
   wire slow_slowest = dvsel | slow_mode; // [R16] [R19]
   logic src_tick; // Selected source pulse.

   always_comb begin
      case (src)
         tcm_pkg::SRC_DIV2048: begin
            src_tick = slow_slowest ? slow8_tick : tick[11];
         end
         tcm_pkg::SRC_DIV128: begin
            src_tick = tick[7];
         end
         tcm_pkg::SRC_DIV32: begin
            src_tick = tick[5];
         end
         tcm_pkg::SRC_DIV8: begin
            src_tick = tick[3];
         end
         tcm_pkg::SRC_SLOW: begin
            src_tick = slow_rise;
         end
         tcm_pkg::SRC_DIV2: begin
            src_tick = tick[1];
         end
         tcm_pkg::SRC_DIV1: begin
            src_tick = tick[0];
         end
         default: begin
            src_tick = 1'b0;
         end
      endcase
   end

   // 16-bit timer has only the four divided sources; in slow mode
   // only slow-clock derived sources may run the counter.
   wire src_four = (src == tcm_pkg::SRC_DIV2048) |
                   (src == tcm_pkg::SRC_DIV128) |
                   (src == tcm_pkg::SRC_DIV32) |
                   (src == tcm_pkg::SRC_DIV8);
   wire src_slowok = (src == tcm_pkg::SRC_DIV2048) |
                     (src == tcm_pkg::SRC_SLOW);
   wire src_ok = (is_t16 ? src_four : 1'b1) &
                 (slow_mode ? src_slowok : 1'b1); // [R16] [R19]

   // Event mode counts pin edges; the rest count the selected source.
   wire count_tick = run & mode_known &
                     (is_event ? evt_fall : (src_tick & src_ok)); // [R1]

   ////////////////////////////////////////////////////////////////////
   // Counter, compare and flip-flop logic.

   wire [15:0] cnt_inc = wide ? cnt + 16'h0001
                              : {8'h00, cnt[7:0] + 8'h01};
   // Compare is read straight from the registers, no shadow.
   wire [15:0] cmp_val = wide ? {compare_high_byte, compare_low_byte}
                              : {8'h00, compare_low_byte}; // [R4]
   wire [15:0] duty_val = wide ? duty_act : {8'h00, duty_act[7:0]};
   wire [15:0] top_val = wide ? 16'hffff : 16'h00ff;
   wire cmp_hit = (cnt_inc == cmp_val); // [R2] [R6] [R17]
   wire ovf_hit = (cnt == top_val); // [R10] [R21]
   wire duty_hit = (cnt_inc == duty_val) & ~ovf_hit; // [R10]

   // A period ends on compare match, or on overflow in PWM modes.
   wire period_end = count_tick &
                     (is_pwm ? ovf_hit : cmp_hit); // [R2] [R10]

   logic [15:0] next_cnt; // Counter value for the coming cycle.

   // Stopped counter clears; a period end clears and restarts.
   always_comb begin
      if (!run) begin
         next_cnt = 16'h0000;
      end else if (period_end) begin
         next_cnt = 16'h0000; // [R2] [R6] [R17]
      end else if (count_tick) begin
         next_cnt = cnt_inc; // [R10]
      end else begin
         next_cnt = cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB decode.

   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr = access & pwrite;
   wire hit_fc = (paddr == tcm_pkg::ADDR_FIRST_CTRL);
   wire hit_sc = (paddr == tcm_pkg::ADDR_SECOND_CTRL);
   wire hit_cl = (paddr == tcm_pkg::ADDR_CMP_LO);
   wire hit_ch = (paddr == tcm_pkg::ADDR_CMP_HI);
   wire hit_dl = (paddr == tcm_pkg::ADDR_DUTY_LO);
   wire hit_dh = (paddr == tcm_pkg::ADDR_DUTY_HI);
   wire hit_cf = (paddr == tcm_pkg::ADDR_CONFIG);
   wire hit_st = (paddr == tcm_pkg::ADDR_STATUS);
   wire mapped = hit_fc | hit_sc | hit_cl | hit_ch |
                 hit_dl | hit_dh | hit_cf | hit_st;
   wire tcm_pkg::tcm_ctrl_t wctrl = pwdata[7:0];
   wire wr_sc = wr & hit_sc;

   // Flip-flop takes the initial value only while already stopped, so
   // the write that stops the timer leaves the pin where it was.
   wire ff_load = wr_sc & ~run; // [R8] [R9]

   // PWM period end toggles again; divider period end toggles once.
   always_comb begin
      next_tff = tff;
      if (ff_load) begin
         next_tff = wctrl.ffinit; // [R7] [R9]
      end else if (count_tick & is_div & period_end) begin
         next_tff = ~tff; // [R6]
      end else if (count_tick & is_pwm & (ovf_hit | duty_hit)) begin
         next_tff = ~tff; // [R10] [R21]
      end
   end

   // During PWM output a duty read shows the stage in use.
   wire duty_show_act = run & is_pwm; // [R13]
   wire [15:0] duty_rd = duty_show_act ? duty_act : duty_buf;
   logic [31:0] rd_mux; // Read data selected by address.

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_fc) begin
         rd_mux[7:0] = first_counter_control;
      end else if (hit_sc) begin
         rd_mux[7:0] = second_counter_control;
      end else if (hit_cl) begin
         rd_mux[7:0] = compare_low_byte;
      end else if (hit_ch) begin
         rd_mux[7:0] = compare_high_byte;
      end else if (hit_dl) begin
         rd_mux[7:0] = duty_rd[7:0]; // [R13]
      end else if (hit_dh) begin
         rd_mux[7:0] = duty_rd[15:8]; // [R13]
      end else if (hit_cf) begin
         rd_mux[1:0] = config_bits;
      end else if (hit_st) begin
         rd_mux[16:0] = {tff, cnt};
      end
   end

   // The slave answers one cycle after setup; unmapped flags an error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register writes.

   // Control and compare registers; compare takes effect at once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_counter_control <= tcm_pkg::CTRL_RESET;
         second_counter_control <= tcm_pkg::CTRL_RESET;
         compare_low_byte <= tcm_pkg::BYTE_RESET;
         compare_high_byte <= tcm_pkg::BYTE_RESET;
         config_bits <= tcm_pkg::CONFIG_RESET;
      end else if (wr) begin
         if (hit_fc) begin
            first_counter_control <= wctrl;
         end
         if (hit_sc) begin
            second_counter_control <= wctrl; // [R9]
         end
         if (hit_cl) begin
            compare_low_byte <= pwdata[7:0]; // [R4]
         end
         if (hit_ch) begin
            compare_high_byte <= pwdata[7:0]; // [R4]
         end
         if (hit_cf) begin
            config_bits <= pwdata[1:0];
         end
      end
   end

   // Duty buffer stage; a write landing with a period end loses the
   // race against the transfer, as software is told to avoid it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_buf <= {tcm_pkg::BYTE_RESET, tcm_pkg::BYTE_RESET};
      end else if (wr & hit_dl) begin
         duty_buf[7:0] <= pwdata[7:0];
      end else if (wr & hit_dh) begin
         duty_buf[15:8] <= pwdata[7:0];
      end
   end

   // Active duty follows the buffer while stopped, else at a PWM period end.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_act <= {tcm_pkg::BYTE_RESET, tcm_pkg::BYTE_RESET};
      end else if (!run) begin
         duty_act <= duty_buf; // [R12]
      end else if (period_end & is_pwm) begin
         duty_act <= duty_buf; // [R12] [R21]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Counter, flip-flop and outputs.

   // Pins are registered copies of the inverted flip-flop, so they
   // change in the same cycle as the status bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 16'h0000;
         tff <= 1'b0; // [R7]
         divider_output_pin <= 1'b1;
         pwm_output_pin <= 1'b1;
         timer_match_interrupt <= 1'b0;
      end else begin
         cnt <= next_cnt; // [R1]
         tff <= next_tff; // [R8]
         divider_output_pin <= ~next_tff; // [R7]
         pwm_output_pin <= ~next_tff; // [R11]
         timer_match_interrupt <= period_end; // [R2] [R17]
      end
   end

endmodule

// >>> test/tcm_props.sv
// Purpose: Port-level checker for the timer/counter block.
// Assumes: APB answers in the cycle after the setup cycle.
// Notes: Bound to the top module from the testbench top file.
`timescale 1ns/1ns
module tcm_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic event_input_pin,
   input wire logic slow_clock_pin,
   input wire logic divider_output_pin,
   input wire logic pwm_output_pin,
   input wire logic timer_match_interrupt
);
   // All checks share the bus clock and its reset.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Off-word or past-the-map addresses must be refused.
   wire unmapped = (paddr[1:0] != 2'h0) || (paddr > tcm_pkg::ADDR_STATUS);

   ////////////////////////////////////////////////////////////////////////
   // Bus phases as named steps.
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_transfer;
      s_setup ##1 s_access;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // Both pins show the inverse of the one flip-flop.
   property p_pins_same;
      divider_output_pin == pwm_output_pin;
   endproperty
   a_pins_same: assert property (p_pins_same)
      else $error("output pins disagree");
   property p_answer;
      s_transfer |-> pready && (pslverr == unmapped);
   endproperty
   a_answer: assert property (p_answer)
      else $error("wrong bus answer");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held too long");
   property p_ready_cause;
      pready |-> s_access and $past(psel && !penable);
   endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready without setup");
   property p_err_only_ready;
      pslverr |-> pready;
   endproperty
   a_err_only_ready: assert property (p_err_only_ready)
      else $error("error without ready");
   property p_rdata_idle;
      !pready |-> prdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside answer");
   property p_rdata_byte;
      pready && !pwrite && (paddr != tcm_pkg::ADDR_STATUS)
         |-> prdata[31:8] == 24'h0;
   endproperty
   a_rdata_byte: assert property (p_rdata_byte)
      else $error("byte register upper bits set");
   property p_status_upper;
      pready && !pwrite && (paddr == tcm_pkg::ADDR_STATUS)
         |-> prdata[31:17] == 15'h0;
   endproperty
   a_status_upper: assert property (p_status_upper)
      else $error("status upper bits set");
   // The main scenario reaches a period end.
   c_irq: cover property (timer_match_interrupt);
endmodule

// >>> test/tcm_partner.sv
// Purpose: Event pulse source and free-running slow oscillator.
// Assumes: The bus clock is the only timing reference.
// Notes: Pulses are started by the bench through the pulse task.
`timescale 1ns/1ns
module tcm_partner (
   input wire logic pclk,
   output logic event_input_pin,
   output logic slow_clock_pin
);
   // Each level is held at least four cycles, twice the least allowed.
   localparam int HOLD = 4;
   // Divider for the slow oscillator, a period of 32 bus cycles.
   logic [3:0] slow_cnt = 4'h0;

   initial begin
      event_input_pin = 1'b1;
      slow_clock_pin = 1'b0;
   end

   // The oscillator runs free, as a crystal would.
   always @(posedge pclk) begin
      slow_cnt <= slow_cnt + 4'h1;
      if (slow_cnt == 4'hf) begin
         slow_clock_pin <= !slow_clock_pin;
      end
   end

   // Send n low pulses; each one gives one falling edge.
   task automatic pulse(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         event_input_pin <= 1'b0;
         repeat (HOLD) @(posedge pclk);
         event_input_pin <= 1'b1;
         repeat (HOLD) @(posedge pclk);
      end
   endtask
endmodule

// >>> test/tcm_top_tb.sv
// Purpose: Self-checking bench for the timer/counter block.
// Assumes: One APB answer per transfer; fast sources for short periods.
// Notes: Sources slower than divide-by-32 are left out for run time.
`timescale 1ns/1ns
module tcm_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, ev_pin, slow_pin, div_pin, pwm_pin, irq;
   int err_count = 0;
   int checks_done = 0;
   int irq_count = 0;
   logic [31:0] rd;
   logic err_bit;
   int gap;
   int base;
   // Source codes and their divide ratios; slow is 32 bus cycles.
   logic [2:0] srcs [5] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h4};
   int divs [5] = '{1, 2, 8, 32, 32};

   always #5 pclk = !pclk;

   tcm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_input_pin(ev_pin), .slow_clock_pin(slow_pin),
      .divider_output_pin(div_pin), .pwm_output_pin(pwm_pin),
      .timer_match_interrupt(irq));
   tcm_partner i_partner (.pclk(pclk), .event_input_pin(ev_pin),
      .slow_clock_pin(slow_pin));

   // Interrupt pulses are counted for the event scenario.
   always @(posedge pclk) begin
      if (irq === 1'b1) begin
         irq_count <= irq_count + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is sampled.
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) err_count++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      check(q & m, exp);
   endtask

   // Cycles until the next interrupt pulse is seen.
   task automatic wait_irq(output int cyc);
      cyc = 0;
      do begin
         @(posedge pclk);
         cyc++;
      end while (irq !== 1'b1 && cyc < 20000);
   endtask

   // Cycles until the PWM pin changes level.
   task automatic wait_pin(output int cyc);
      logic p;
      p = pwm_pin;
      cyc = 0;
      do begin
         @(posedge pclk);
         cyc++;
      end while (pwm_pin === p && cyc < 1000);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the roughly 45000 cycles of the tests.
   initial begin
      #900000;
      err_count++;
      report_and_stop;
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({31'h0, div_pin}, 32'h1);
      rd_chk(tcm_pkg::ADDR_SECOND_CTRL, 32'hff, 32'h0);
      rd_chk(tcm_pkg::ADDR_STATUS, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h20, 32'h0, rd, err_bit);
      check({31'h0, err_bit}, 32'h1);
      // Event counting with the initial bit kept at zero.
      wr(tcm_pkg::ADDR_CMP_LO, 32'h05);
      wr(tcm_pkg::ADDR_CMP_HI, 32'h00);
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'h0a);
      i_partner.pulse(3);
      repeat (8) @(posedge pclk);
      rd_chk(tcm_pkg::ADDR_STATUS, 32'hffff, 32'h3);
      wr(tcm_pkg::ADDR_CMP_LO, 32'h04);
      base = irq_count;
      i_partner.pulse(1);
      repeat (8) @(posedge pclk);
      check(irq_count - base, 32'h1);
      rd_chk(tcm_pkg::ADDR_STATUS, 32'hffff, 32'h0);
      i_partner.pulse(2);
      repeat (8) @(posedge pclk);
      rd_chk(tcm_pkg::ADDR_STATUS, 32'hffff, 32'h2);
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'h02);
      i_partner.pulse(2);
      repeat (8) @(posedge pclk);
      rd_chk(tcm_pkg::ADDR_STATUS, 32'hffff, 32'h0);
      // Divider output from the bus clock.
      wr(tcm_pkg::ADDR_CMP_LO, 32'h40);
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'h69);
      wait_irq(gap);
      rd = {31'h0, div_pin};
      wait_irq(gap);
      check(gap, 32'd64);
      check({31'h0, div_pin}, ~rd & 32'h1);
      while (div_pin !== 1'b1) @(posedge pclk);
      // Stop carrying a changed initial bit: the pin must hold.
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'he1);
      repeat (100) @(posedge pclk);
      check({31'h0, div_pin}, 32'h1);
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'he1);
      repeat (3) @(posedge pclk);
      check({31'h0, div_pin}, 32'h0);
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'h61);
      repeat (3) @(posedge pclk);
      check({31'h0, div_pin}, 32'h1);
      // PWM with a duty loaded while stopped.
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'h01);
      wr(tcm_pkg::ADDR_DUTY_LO, 32'h40);
      rd_chk(tcm_pkg::ADDR_DUTY_LO, 32'hff, 32'h40);
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'h6b);
      wait_irq(gap);
      check({31'h0, pwm_pin}, 32'h1);
      wait_pin(gap);
      check(gap, 32'h40);
      wait_irq(gap);
      check(gap, 32'd192);
      wr(tcm_pkg::ADDR_DUTY_LO, 32'h20);
      rd_chk(tcm_pkg::ADDR_DUTY_LO, 32'hff, 32'h40);
      wait_irq(gap);
      wait_pin(gap);
      check(gap, 32'h20);
      rd_chk(tcm_pkg::ADDR_DUTY_LO, 32'hff, 32'h20);
      for (int i = 0; i < 5; i++) begin
         wr(tcm_pkg::ADDR_SECOND_CTRL, {24'h0, 1'b0, srcs[i], 4'hb});
         wait_irq(gap);
         wait_irq(gap);
         check(gap, 256 * divs[i]);
      end
      // Sixteen-bit interval with the high byte in use.
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'h03);
      wr(tcm_pkg::ADDR_CMP_LO, 32'h2c);
      wr(tcm_pkg::ADDR_CMP_HI, 32'h01);
      wr(tcm_pkg::ADDR_FIRST_CTRL, 32'h30);
      wr(tcm_pkg::ADDR_CONFIG, 32'h02);
      wr(tcm_pkg::ADDR_SECOND_CTRL, 32'h3c);
      repeat (40) @(posedge pclk);
      rd_chk(tcm_pkg::ADDR_STATUS, 32'hffff, 32'h0);
      wr(tcm_pkg::ADDR_CONFIG, 32'h00);
      wait_irq(gap);
      wait_irq(gap);
      check(gap, 32'd2400);
      report_and_stop;
   end
endmodule

bind tcm_top tcm_props i_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .event_input_pin(event_input_pin), .slow_clock_pin(slow_clock_pin),
   .divider_output_pin(divider_output_pin),
   .pwm_output_pin(pwm_output_pin),
   .timer_match_interrupt(timer_match_interrupt));
